// >>> inc/charge_timer_control_defs.vh
// Constants for the charger supervisory timer block.
`ifndef CHARGE_TIMER_CONTROL_DEFS_VH
`define CHARGE_TIMER_CONTROL_DEFS_VH

`define CTC_ADDR_W 8
`define CTC_DATA_W 16
`define CTC_ADDR_CFG 8'h00
`define CTC_ADDR_CTRL 8'h04
`define CTC_ADDR_STATUS 8'h08
`define CTC_ADDR_IRQ_STAT 8'h0C
`define CTC_ADDR_IRQ_MASK 8'h10

`define CTC_CFG_W 10
`define CTC_CFG_RESET 10'h055
`define CTC_CFG_PREQ 1:0
`define CTC_CFG_FAST 3:2
`define CTC_CFG_MAINT 5:4
`define CTC_CFG_DONE 7:6
`define CTC_CFG_RECHG 9:8

`define CTC_CTRL_ENABLE 0
`define CTC_CTRL_SOFT 1
`define CTC_CTRL_HARD 2
`define CTC_CTRL_RESET 1'h1

`define CTC_IRQ_W 2
`define CTC_IRQ_FAULT 0
`define CTC_IRQ_DONE 1
`define CTC_IRQ_MASK_RESET 2'h0

`define CTC_MIN_W 10
`define CTC_PREQ_T0 10'd30
`define CTC_PREQ_T1 10'd60
`define CTC_PREQ_T2 10'd120
`define CTC_PREQ_T3 10'd240
`define CTC_FAST_T0 10'd75
`define CTC_FAST_T1 10'd150
`define CTC_FAST_T2 10'd300
`define CTC_FAST_T3 10'd600
`define CTC_MAINT_T0 10'd0
`define CTC_MAINT_T1 10'd15
`define CTC_MAINT_T2 10'd30
`define CTC_MAINT_T3 10'd60

`define CTC_CLK_MHZ 250
`define CTC_MINUTE_S 60
`define CTC_SOFT_RST_MS 10
`define CTC_HARD_RST_MS 50

`define CTC_ST_W 6
`define CTC_ST_IDLE 6'h01
`define CTC_ST_PREQ 6'h02
`define CTC_ST_FAST 6'h04
`define CTC_ST_MAINT 6'h08
`define CTC_ST_DONE 6'h10
`define CTC_ST_FAULT 6'h20

`endif

// >>> src/charge_timer_control.v
// Charger phase timers, timer slow-down and reset handling for a linear battery charger.
`include "charge_timer_control_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module charge_timer_control #(
	parameter [35:0] MINUTE_CYCLES = 36'd1000000 * `CTC_CLK_MHZ * `CTC_MINUTE_S,
	parameter [31:0] SOFT_RST_CYCLES = 32'd1000 * `CTC_CLK_MHZ * `CTC_SOFT_RST_MS,
	parameter [31:0] HARD_RST_CYCLES = 32'd1000 * `CTC_CLK_MHZ * `CTC_HARD_RST_MS
) (
	input wire clk,
	input wire reset_n,
	input wire clk_en,
	input wire [`CTC_ADDR_W-1:0] reg_addr,
	input wire [`CTC_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [`CTC_DATA_W-1:0] reg_rdata,
	input wire current_limited,
	input wire below_half_current,
	input wire below_fifth_current,
	input wire battery_above_prequal,
	input wire below_done_current,
	input wire below_recharge_level,
	output reg charge_on,
	output reg fast_phase_current,
	output reg [1:0] done_current_sel,
	output reg [1:0] recharge_margin_sel,
	output reg rst_out_n,
	output reg por_restart,
	output reg irq
);

	localparam NSYNC = 6;

	reg [NSYNC-1:0] sync1_q;
	reg [NSYNC-1:0] sync2_q;
	reg [NSYNC-1:0] sync3_q;
	reg [NSYNC-1:0] clean_q;
	wire [NSYNC-1:0] raw_in;
	wire lim_s;
	wire half_s;
	wire fifth_s;
	wire bat_ok_s;
	wire done_i_s;
	wire rechg_s;

	reg [`CTC_CFG_W-1:0] cfg_q;
	reg enable_q;
	reg [`CTC_IRQ_W-1:0] irq_stat_q;
	reg [`CTC_IRQ_W-1:0] irq_mask_q;
	reg [`CTC_IRQ_W-1:0] irq_stat_d;
	reg [`CTC_ST_W-1:0] state_q;
	reg [`CTC_ST_W-1:0] state_d;
	reg fault_q;
	reg [35:0] presc_q;
	reg half_phase_q;
	reg [`CTC_MIN_W-1:0] minutes_q;
	reg [31:0] rst_cnt_q;
	reg hard_q;

	wire wr_cfg;
	wire wr_ctrl;
	wire wr_irq_stat;
	wire wr_irq_mask;
	wire soft_req;
	wire hard_req;
	wire slowed;
	wire paused;
	wire advance;
	wire minute_tick;
	wire entering;
	wire [`CTC_MIN_W-1:0] preq_limit;
	wire [`CTC_MIN_W-1:0] fast_limit;
	wire [`CTC_MIN_W-1:0] maint_limit;
	wire preq_expired;
	wire fast_expired;
	wire maint_expired;
	wire ev_fault;
	wire ev_done;

	function [`CTC_MIN_W-1:0] pick;
		input [1:0] sel;
		input [`CTC_MIN_W-1:0] t0;
		input [`CTC_MIN_W-1:0] t1;
		input [`CTC_MIN_W-1:0] t2;
		input [`CTC_MIN_W-1:0] t3;
		begin
			case (sel)
				2'h0: pick = t0;
				2'h1: pick = t1;
				2'h2: pick = t2;
				default: pick = t3;
			endcase
		end
	endfunction

	// Comparator outputs come from the analog loop and are resynchronised here.
	assign raw_in = {below_recharge_level, below_done_current, battery_above_prequal,
		below_fifth_current, below_half_current, current_limited};
	assign lim_s = clean_q[0];
	assign half_s = clean_q[1];
	assign fifth_s = clean_q[2];
	assign bat_ok_s = clean_q[3];
	assign done_i_s = clean_q[4];
	assign rechg_s = clean_q[5];

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
					clean_q[gi] <= 1'b0;
				end else if (clk_en) begin
					sync1_q[gi] <= raw_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (sync2_q[gi] == sync3_q[gi]) begin
						clean_q[gi] <= sync3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign wr_cfg = reg_wr && (reg_addr == `CTC_ADDR_CFG);
	assign wr_ctrl = reg_wr && (reg_addr == `CTC_ADDR_CTRL);
	assign wr_irq_stat = reg_wr && (reg_addr == `CTC_ADDR_IRQ_STAT);
	assign wr_irq_mask = reg_wr && (reg_addr == `CTC_ADDR_IRQ_MASK);
	assign soft_req = wr_ctrl && reg_wdata[`CTC_CTRL_SOFT];
	assign hard_req = wr_ctrl && reg_wdata[`CTC_CTRL_HARD];

	assign preq_limit = pick(cfg_q[`CTC_CFG_PREQ], `CTC_PREQ_T0, `CTC_PREQ_T1,
		`CTC_PREQ_T2, `CTC_PREQ_T3);
	assign fast_limit = pick(cfg_q[`CTC_CFG_FAST], `CTC_FAST_T0, `CTC_FAST_T1,
		`CTC_FAST_T2, `CTC_FAST_T3);
	assign maint_limit = pick(cfg_q[`CTC_CFG_MAINT], `CTC_MAINT_T0, `CTC_MAINT_T1,
		`CTC_MAINT_T2, `CTC_MAINT_T3);

	// The timer only slows or stops when current is cut back by limiting or heat.
	assign paused = lim_s && fifth_s;
	assign slowed = lim_s && half_s && !fifth_s;
	assign advance = !paused && (!slowed || half_phase_q);
	// Exact cycle count per minute keeps the timer far inside its tolerance.
	assign minute_tick = advance && (presc_q == MINUTE_CYCLES - 36'd1);
	assign entering = (state_d != state_q);

	assign preq_expired = (minutes_q >= preq_limit);
	assign fast_expired = (minutes_q >= fast_limit);
	assign maint_expired = (minutes_q >= maint_limit);

	always @* begin
		state_d = state_q;
		if (!enable_q) begin
			state_d = `CTC_ST_IDLE;
		end else begin
			case (state_q)
				`CTC_ST_IDLE: state_d = `CTC_ST_PREQ;
				`CTC_ST_PREQ: begin
					if (bat_ok_s) begin
						state_d = `CTC_ST_FAST;
					end else if (preq_expired) begin
						state_d = `CTC_ST_FAULT;
					end
				end
				`CTC_ST_FAST: begin
					if (done_i_s) begin
						if (maint_limit == `CTC_MAINT_T0) begin
							state_d = `CTC_ST_DONE;
						end else begin
							state_d = `CTC_ST_MAINT;
						end
					end else if (fast_expired) begin
						state_d = `CTC_ST_FAULT;
					end
				end
				`CTC_ST_MAINT: begin
					if (maint_expired) begin
						state_d = `CTC_ST_DONE;
					end
				end
				`CTC_ST_DONE: begin
					if (rechg_s) begin
						state_d = `CTC_ST_PREQ;
					end
				end
				`CTC_ST_FAULT: state_d = `CTC_ST_FAULT;
				default: state_d = `CTC_ST_IDLE;
			endcase
		end
	end

	assign ev_fault = (state_d == `CTC_ST_FAULT) && (state_q != `CTC_ST_FAULT);
	assign ev_done = (state_d == `CTC_ST_DONE) && (state_q != `CTC_ST_DONE);

	// A new event wins over a write-one-to-clear in the same cycle.
	always @* begin
		irq_stat_d = irq_stat_q;
		if (wr_irq_stat) begin
			irq_stat_d = irq_stat_q & ~reg_wdata[`CTC_IRQ_W-1:0];
		end
		if (ev_fault) begin
			irq_stat_d[`CTC_IRQ_FAULT] = 1'b1;
		end
		if (ev_done) begin
			irq_stat_d[`CTC_IRQ_DONE] = 1'b1;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q <= `CTC_CFG_RESET;
			enable_q <= `CTC_CTRL_RESET;
			irq_mask_q <= `CTC_IRQ_MASK_RESET;
			irq_stat_q <= {`CTC_IRQ_W{1'b0}};
			state_q <= `CTC_ST_IDLE;
			fault_q <= 1'b0;
			presc_q <= 36'h0;
			half_phase_q <= 1'b0;
			minutes_q <= {`CTC_MIN_W{1'b0}};
		end else if (clk_en) begin
			if (hard_q || hard_req) begin
				// A hard reset restarts the control, state and timer registers as after power-on; the input synchronisers keep their values.
				cfg_q <= `CTC_CFG_RESET;
				enable_q <= `CTC_CTRL_RESET;
				irq_mask_q <= `CTC_IRQ_MASK_RESET;
				irq_stat_q <= {`CTC_IRQ_W{1'b0}};
				state_q <= `CTC_ST_IDLE;
				fault_q <= 1'b0;
				presc_q <= 36'h0;
				half_phase_q <= 1'b0;
				minutes_q <= {`CTC_MIN_W{1'b0}};
			end else begin
				if (soft_req) begin
					cfg_q <= `CTC_CFG_RESET;
					enable_q <= `CTC_CTRL_RESET;
					irq_mask_q <= `CTC_IRQ_MASK_RESET;
				end else begin
					if (wr_cfg) begin
						cfg_q <= reg_wdata[`CTC_CFG_W-1:0];
					end
					if (wr_ctrl) begin
						enable_q <= reg_wdata[`CTC_CTRL_ENABLE];
					end
					if (wr_irq_mask) begin
						irq_mask_q <= reg_wdata[`CTC_IRQ_W-1:0];
					end
				end
				irq_stat_q <= irq_stat_d;
				state_q <= state_d;
				if (ev_fault) begin
					fault_q <= 1'b1;
				end else if (state_d == `CTC_ST_IDLE) begin
					fault_q <= 1'b0;
				end
				if (entering) begin
					presc_q <= 36'h0;
					half_phase_q <= 1'b0;
					minutes_q <= {`CTC_MIN_W{1'b0}};
				end else begin
					if (slowed) begin
						half_phase_q <= !half_phase_q;
					end
					if (minute_tick) begin
						presc_q <= 36'h0;
						if (minutes_q != {`CTC_MIN_W{1'b1}}) begin
							minutes_q <= minutes_q + 1'b1;
						end
					end else if (advance) begin
						presc_q <= presc_q + 36'h1;
					end
				end
			end
		end
	end

	// Reset output pulse: soft reset gives the short pulse, hard reset the long one.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_cnt_q <= 32'h0;
			hard_q <= 1'b0;
			rst_out_n <= 1'b0;
			por_restart <= 1'b0;
		end else if (clk_en) begin
			if (hard_req) begin
				rst_cnt_q <= HARD_RST_CYCLES;
				hard_q <= 1'b1;
				rst_out_n <= 1'b0;
				por_restart <= 1'b1;
			end else if (soft_req && !hard_q) begin
				rst_cnt_q <= SOFT_RST_CYCLES;
				rst_out_n <= 1'b0;
			end else if (rst_cnt_q > 32'h1) begin
				rst_cnt_q <= rst_cnt_q - 32'h1;
				rst_out_n <= 1'b0;
			end else begin
				rst_cnt_q <= 32'h0;
				hard_q <= 1'b0;
				rst_out_n <= 1'b1;
				por_restart <= 1'b0;
			end
		end
	end

	// Outputs to the analog charger and the interrupt pin.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			charge_on <= 1'b0;
			fast_phase_current <= 1'b0;
			done_current_sel <= 2'h0;
			recharge_margin_sel <= 2'h0;
			irq <= 1'b0;
		end else if (clk_en) begin
			charge_on <= (state_q == `CTC_ST_PREQ) || (state_q == `CTC_ST_FAST) ||
				(state_q == `CTC_ST_MAINT);
			fast_phase_current <= (state_q == `CTC_ST_FAST) || (state_q == `CTC_ST_MAINT);
			done_current_sel <= cfg_q[`CTC_CFG_DONE];
			recharge_margin_sel <= cfg_q[`CTC_CFG_RECHG];
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= {`CTC_DATA_W{1'b0}};
		end else if (clk_en) begin
			reg_rdata <= {`CTC_DATA_W{1'b0}};
			if (reg_rd) begin
				case (reg_addr)
					`CTC_ADDR_CFG: reg_rdata <= {6'h0, cfg_q};
					`CTC_ADDR_CTRL: reg_rdata <= {15'h0, enable_q};
					`CTC_ADDR_STATUS: reg_rdata <= {6'h0, paused, slowed, fault_q, 1'b0, state_q};
					`CTC_ADDR_IRQ_STAT: reg_rdata <= {14'h0, irq_stat_q};
					`CTC_ADDR_IRQ_MASK: reg_rdata <= {14'h0, irq_mask_q};
					default: reg_rdata <= {`CTC_DATA_W{1'b0}};
				endcase
			end
		end
	end

endmodule // charge_timer_control

`default_nettype wire

// >>> testbench/charge_timer_control_asserts.sv
// Port checker for the charger timer block.
`timescale 1ns/1ps
`default_nettype none
module ctc_checker #(
	parameter [35:0] MINUTE_CYCLES = 36'd20,
	parameter [31:0] SOFT_RST_CYCLES = 32'd5,
	parameter [31:0] HARD_RST_CYCLES = 32'd10
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic charge_on,
	input wire logic fast_phase_current,
	input wire logic [1:0] done_current_sel,
	input wire logic [1:0] recharge_margin_sel,
	input wire logic rst_out_n,
	input wire logic por_restart,
	input wire logic irq
);
	logic [3:0] sel_q;
	wire quiet = rst_out_n && !por_restart;
	wire wc = clk_en && reg_wr && reg_addr == 8'h04 && quiet;
	wire wf = clk_en && reg_wr && reg_addr == 8'h00 && quiet;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	always @(posedge clk) begin
		if (wf) begin
			sel_q <= reg_wdata[9:6];
		end
	end
	sequence soft_low; !rst_out_n [*5] ##1 rst_out_n; endsequence
	sequence hard_high; por_restart [*8] ##[2:3] !por_restart; endsequence
	rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not idle");
	soft_pulse_a: assert property (wc && reg_wdata[2:1] == 2'h1 |=> soft_low)
		else $error("soft reset pulse wrong");
	hard_pulse_a: assert property (wc && reg_wdata[2] |=> hard_high)
		else $error("hard reset pulse wrong");
	hard_quiet_a: assert property (por_restart && $past(por_restart) |->
		!rst_out_n && !charge_on && !irq) else $error("activity during hard reset");
	phase_order_a: assert property (fast_phase_current |-> charge_on)
		else $error("fast current without charging");
	stop_charge_a: assert property (wc && reg_wdata[2:0] == 3'h0 |-> ##[1:3] !charge_on)
		else $error("charging not stopped");
	start_charge_a: assert property (wc && reg_wdata[2:0] == 3'h0 ##1
		wc && reg_wdata[2:0] == 3'h1 |-> ##[1:3] charge_on) else $error("charging not started");
	sel_copy_a: assert property (wf ##1 !wf && !wc |->
		##1 {recharge_margin_sel, done_current_sel} == sel_q) else $error("select copy wrong");
endmodule // ctc_checker
bind charge_timer_control ctc_checker #(.MINUTE_CYCLES(MINUTE_CYCLES),
	.SOFT_RST_CYCLES(SOFT_RST_CYCLES), .HARD_RST_CYCLES(HARD_RST_CYCLES)) ctc_checker_i (
	.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.charge_on(charge_on), .fast_phase_current(fast_phase_current),
	.done_current_sel(done_current_sel), .recharge_margin_sel(recharge_margin_sel),
	.rst_out_n(rst_out_n), .por_restart(por_restart), .irq(irq));
`default_nettype wire

// >>> testbench/charger_analog_model.sv
// Behavioural model of the analog charge loop and its current comparators.
`timescale 1ns/1ps
`default_nettype none
module charger_analog_model (
	input wire logic clk,
	input wire logic [1:0] lim,
	input wire logic bat,
	input wire logic tap,
	input wire logic sag,
	input wire logic charge_on,
	input wire logic fast_phase_current,
	output logic current_limited = 1'b0,
	output logic below_half_current = 1'b0,
	output logic below_fifth_current = 1'b0,
	output logic battery_above_prequal = 1'b0,
	output logic below_done_current = 1'b0,
	output logic below_recharge_level = 1'b0
);
	// With the charger off no current flows, so both below-fraction comparators read high.
	always @(posedge clk) begin
		current_limited <= charge_on && lim != 2'h0;
		below_half_current <= !charge_on || lim != 2'h0;
		below_fifth_current <= !charge_on || lim == 2'h2;
		battery_above_prequal <= bat;
		below_done_current <= fast_phase_current && tap;
		below_recharge_level <= sag;
	end
endmodule // charger_analog_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the charger timer block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
	localparam int M = 20;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] lim = 2'h0;
	logic bat = 1'b0;
	logic tap = 1'b0;
	logic sag = 1'b0;
	wire [15:0] reg_rdata;
	wire current_limited, below_half_current, below_fifth_current, battery_above_prequal;
	wire below_done_current, below_recharge_level, charge_on, fast_phase_current;
	wire [1:0] done_current_sel, recharge_margin_sel;
	wire rst_out_n, por_restart, irq;
	int num_errors = 0;
	int samples_checked = 0;
	int seed = 42;
	int n;
	logic [3:0] r;
	int pq[4] = '{30, 60, 120, 240};
	int fs[4] = '{75, 150, 300, 600};
	int mt[4] = '{0, 15, 30, 60};
	always #2 clk = ~clk;
	charge_timer_control #(.MINUTE_CYCLES(36'd20), .SOFT_RST_CYCLES(32'd5),
		.HARD_RST_CYCLES(32'd10)) charge_timer_control_i (.clk(clk), .reset_n(reset_n),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .current_limited(current_limited),
		.below_half_current(below_half_current), .below_fifth_current(below_fifth_current),
		.battery_above_prequal(battery_above_prequal), .below_done_current(below_done_current),
		.below_recharge_level(below_recharge_level), .charge_on(charge_on),
		.fast_phase_current(fast_phase_current), .done_current_sel(done_current_sel),
		.recharge_margin_sel(recharge_margin_sel), .rst_out_n(rst_out_n),
		.por_restart(por_restart), .irq(irq));
	charger_analog_model charger_analog_model_i (.clk(clk), .lim(lim), .bat(bat), .tap(tap),
		.sag(sag), .charge_on(charge_on), .fast_phase_current(fast_phase_current),
		.current_limited(current_limited), .below_half_current(below_half_current),
		.below_fifth_current(below_fifth_current), .battery_above_prequal(battery_above_prequal),
		.below_done_current(below_done_current), .below_recharge_level(below_recharge_level));
	task complete_run;
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input [7:0] a, input [15:0] v, input bit k = 0);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		if (!k) begin
			reg_wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [7:0] a, input [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK("reg_rdata", e, reg_rdata)
		@(posedge clk);
	endtask
	task meas(input logic w, input int lc, input bit ok);
		n = 0;
		#1;
		while (charge_on !== w && n < lc) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= lc && !ok) begin
			num_errors++;
			complete_run();
		end
	endtask
	function automatic bit win(int nom, int got);
		return got * 10 >= nom * 9 && got <= nom * 11 / 10 + 24;
	endfunction
	function automatic [15:0] mk(input [1:0] p, input [1:0] f, input [1:0] m, input [3:0] q);
		return {6'h00, q, m, f, p};
	endfunction
	task trial(input [15:0] cfg, input [1:0] lm, input logic b, input logic t);
		wr(8'h00, cfg);
		wr(8'h04, 16'h0000, 1);
		wr(8'h04, 16'h0001);
		lim <= lm;
		bat <= b;
		tap <= t;
		sag <= 1'b0;
		meas(1'b1, 50, 0);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(8'h00, 16'h0055);
		rd(8'h14, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			wr(8'h10, {15'h0000, c[0]});
			trial(mk(c[1:0], 2'h0, 2'h1, 4'($random(seed))), 2'h0, 1'b0, 1'b0);
			meas(1'b0, 6000, 0);
			`CHK("prequal_time", 1'b1, win(pq[c] * M, n))
			repeat (3) @(posedge clk);
			`CHK("irq", c[0], irq)
			rd(8'h0C, 16'h0001);
			rd(8'h08, 16'h00A0);
			wr(8'h0C, 16'h0001);
			#1 `CHK("irq_clear", 1'b0, irq)
		end
		trial(16'h0000, 2'h1, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		rd(8'h08, 16'h0102);
		meas(1'b0, 6000, 0);
		`CHK("half_rate", 1'b1, win(30 * M * 2, n))
		trial(16'h0000, 2'h2, 1'b0, 1'b0);
		meas(1'b0, 2000, 1);
		`CHK("paused", 1'b1, charge_on)
		rd(8'h08, 16'h0202);
		lim <= 2'h0;
		meas(1'b0, 6000, 0);
		`CHK("resumed", 1'b1, win(30 * M, n))
		for (int c = 0; c < 4; c++) begin
			trial(mk(2'h0, c[1:0], 2'h1, 4'($random(seed))), 2'h0, 1'b1, 1'b0);
			meas(1'b0, 14000, 0);
			`CHK("fast_time", 1'b1, win(fs[c] * M, n))
		end
		for (int c = 0; c < 4; c++) begin
			r = 4'($random(seed));
			trial(mk(2'h0, 2'h0, c[1:0], r), 2'h0, 1'b1, 1'b1);
			`CHK("done_sel", r[1:0], done_current_sel)
			`CHK("recharge_sel", r[3:2], recharge_margin_sel)
			meas(1'b0, 2000, 0);
			`CHK("maintain_time", 1'b1, win(mt[c] * M, n))
			sag <= 1'b1;
			meas(1'b1, 40, 0);
			`CHK("recharge", 1'b1, charge_on)
		end
		wr(8'h00, 16'h03FF);
		wr(8'h04, 16'h0002);
		#1 `CHK("rst_out_n", 1'b0, rst_out_n)
		repeat (8) @(posedge clk);
		rd(8'h00, 16'h0055);
		rd(8'h10, 16'h0000);
		rd(8'h04, 16'h0001);
		// A write while the clock enable is low must be lost.
		clk_en <= 1'b0;
		wr(8'h00, 16'h0000);
		clk_en <= 1'b1;
		rd(8'h00, 16'h0055);
		wr(8'h00, 16'h03FF);
		wr(8'h04, 16'h0004);
		#1 `CHK("por_restart", 1'b1, por_restart)
		`CHK("charge_off", 1'b0, charge_on)
		repeat (12) @(posedge clk);
		rd(8'h00, 16'h0055);
		`CHK("por_end", 1'b0, por_restart)
		complete_run();
	end
endmodule // testbench
`default_nettype wire
